// file: rtl/cgsr_pkg.sv
// Purpose: constants and types shared by the clock gate and soft reset block
// Assumes: APB slave, 32-bit data, 12-bit byte address
// Notes:   offsets are byte addresses of aligned words

package cgsr_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int PORT_N = 8;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SOFTWARE_RESET_CTRL_0_OFS = 12'h040;
    localparam logic [ADDR_W-1:0] RUN_MODE_CLOCK_CONFIG_OFS = 12'h060;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS            = 12'h070;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS              = 12'h074;
    localparam logic [ADDR_W-1:0] RUN_PORT_CLOCK_GATE_OFS   = 12'h108;
    localparam logic [ADDR_W-1:0] SLEEP_PORT_CLOCK_GATE_OFS = 12'h118;
    localparam logic [ADDR_W-1:0] DEEP_PORT_CLOCK_GATE_OFS  = 12'h128;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] GATE_RESET  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] SRCR_RESET  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CFG_RESET   = 32'h0000_0000;
    localparam logic [DATA_W-1:0] IRQ_RESET   = 32'h0000_0000;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CONVERTER_RESET_BIT   = 16;
    localparam int HIBERNATION_RESET_BIT = 6;
    localparam int WATCHDOG_RESET_BIT    = 3;
    localparam int AUTO_CLOCK_GATING_BIT = 0;
    localparam logic [DATA_W-1:0] SRCR_WRITABLE = 32'h0001_0048;
    localparam logic [DATA_W-1:0] GATE_WRITABLE = 32'h0000_00FF;

    // ----------------------------------------------------------------
    // power modes, gray coded run -> sleep -> deep sleep
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_RUN   = 2'h0,
        PWR_SLEEP = 2'h1,
        PWR_DEEP  = 2'h3
    } cgsr_pwr_mode_e;

endpackage

// file: rtl/cgsr_clock_gate_soft_reset.sv
// Purpose: port clock gating per power mode and software reset control
// Assumes: APB master on mclk, power mode and port accesses from mclk logic
// Notes:   zero wait state slave; read data is captured in the setup cycle

`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - bits 7..0 of a gating register enable clocks of ports A..H.
// - access to a port whose clock is gated answers with a bus fault.
// - all gating enables clear at reset, ports start unclocked.
// - deep-sleep gating register at 0x128 governs ports in deep sleep.
// - sleep and deep-sleep gating apply only with auto gating set.
// - gating register bits 31:8 read zero and ignore writes.
// - reset control writes at 0x040 are masked by capability bits.
// - reset control bit 16 resets the converter module.
// - reset control bit 6 resets the hibernation module.
// - reset control bit 3 resets the watchdog unit.
// - reset control reserved bits read zero; control bits reset to zero.
module cgsr_clock_gate_soft_reset
    import cgsr_pkg::*;
(
    input  wire logic                           mclk,
    input  wire logic                           reset,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [cgsr_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [cgsr_pkg::DATA_W-1:0]    pwdata,
    output var  logic [cgsr_pkg::DATA_W-1:0]    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire cgsr_pkg::cgsr_pwr_mode_e       powerMode,
    input  wire logic [cgsr_pkg::DATA_W-1:0]    capabilityMask1,
    input  wire logic [cgsr_pkg::PORT_N-1:0]    portAccess,
    output logic      [cgsr_pkg::PORT_N-1:0]    portBusFault,
    output var  logic [cgsr_pkg::PORT_N-1:0]    portClockEnable,
    output var  logic                           converterResetHold,
    output var  logic                           hibernationResetHold,
    output var  logic                           watchdogResetHold,
    output var  logic                           irq
);

    import cgsr_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            SOFTWARE_RESET_CTRL_0_OFS,
            RUN_MODE_CLOCK_CONFIG_OFS,
            IRQ_STATUS_OFS,
            IRQ_MASK_OFS,
            RUN_PORT_CLOCK_GATE_OFS,
            SLEEP_PORT_CLOCK_GATE_OFS,
            DEEP_PORT_CLOCK_GATE_OFS:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
        return hit;
    endfunction

    // masked update: only bits set in keep may change
    function automatic logic [DATA_W-1:0] maskedWrite(
        input logic [DATA_W-1:0] oldValue,
        input logic [DATA_W-1:0] newValue,
        input logic [DATA_W-1:0] keep
    );
        return (newValue & keep) | (oldValue & ~keep);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] runGate;
    logic [DATA_W-1:0] sleepGate;
    logic [DATA_W-1:0] deepGate;
    logic [DATA_W-1:0] resetCtrl;
    logic [DATA_W-1:0] clockConfig;
    logic [DATA_W-1:0] irqStatus;
    logic [DATA_W-1:0] irqMask;

    logic [DATA_W-1:0] next_runGate;
    logic [DATA_W-1:0] next_sleepGate;
    logic [DATA_W-1:0] next_deepGate;
    logic [DATA_W-1:0] next_resetCtrl;
    logic [DATA_W-1:0] next_clockConfig;
    logic [DATA_W-1:0] next_irqStatus;
    logic [DATA_W-1:0] next_irqMask;
    logic [DATA_W-1:0] next_prdata;
    logic [PORT_N-1:0] next_portClockEnable;
    logic              next_irq;

    logic              setupPhase;
    logic              accessPhase;
    logic              writeDone;
    logic              addrHit;
    logic [DATA_W-1:0] readValue;
    logic [DATA_W-1:0] faultEvent;
    logic [DATA_W-1:0] gateInForce;

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    assign pready      = 1'b1;
    assign setupPhase  = psel & ~penable;
    assign accessPhase = psel & penable;
    assign addrHit     = isMapped(paddr);
    assign pslverr     = accessPhase & ~addrHit;
    assign writeDone   = accessPhase & pwrite & addrHit;

    // ----------------------------------------------------------------
    // port bus fault
    // ----------------------------------------------------------------
    // a gated port cannot answer, so the fault is raised here instead
    assign portBusFault = portAccess & ~portClockEnable;
    assign faultEvent   = {{(DATA_W-PORT_N){1'b0}}, portBusFault};

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        readValue = 32'h0000_0000;
        case (paddr)
            SOFTWARE_RESET_CTRL_0_OFS:
                readValue = resetCtrl & SRCR_WRITABLE;
            RUN_MODE_CLOCK_CONFIG_OFS:
                readValue = clockConfig;
            IRQ_STATUS_OFS:
                readValue = irqStatus;
            IRQ_MASK_OFS:
                readValue = irqMask;
            RUN_PORT_CLOCK_GATE_OFS:
                readValue = runGate & GATE_WRITABLE;
            SLEEP_PORT_CLOCK_GATE_OFS:
                readValue = sleepGate & GATE_WRITABLE;
            DEEP_PORT_CLOCK_GATE_OFS:
                readValue = deepGate & GATE_WRITABLE;
            default:
                readValue = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // gate selection
    // ----------------------------------------------------------------
    // without auto gating the run setting stays in force in every mode
    always_comb
    begin
        gateInForce = runGate;
        if (clockConfig[AUTO_CLOCK_GATING_BIT])
        begin
            case (powerMode)
                PWR_SLEEP:
                    gateInForce = sleepGate;
                PWR_DEEP:
                    gateInForce = deepGate;
                default:
                    gateInForce = runGate;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    always_comb
    begin
        next_runGate     = runGate;
        next_sleepGate   = sleepGate;
        next_deepGate    = deepGate;
        next_resetCtrl   = resetCtrl;
        next_clockConfig = clockConfig;
        next_irqMask     = irqMask;
        next_irqStatus   = irqStatus;
        next_prdata      = prdata;

        // capture in setup so prdata comes from a flop with no wait state
        if (setupPhase)
        begin
            next_prdata = readValue;
        end

        if (writeDone)
        begin
            case (paddr)
                SOFTWARE_RESET_CTRL_0_OFS:
                    next_resetCtrl = maskedWrite(resetCtrl, pwdata,
                        capabilityMask1 & SRCR_WRITABLE);
                RUN_MODE_CLOCK_CONFIG_OFS:
                    next_clockConfig = maskedWrite(clockConfig, pwdata,
                        32'h0000_0001 << AUTO_CLOCK_GATING_BIT);
                IRQ_MASK_OFS:
                    next_irqMask = pwdata & GATE_WRITABLE;
                IRQ_STATUS_OFS:
                    next_irqStatus = irqStatus & ~pwdata;
                RUN_PORT_CLOCK_GATE_OFS:
                    next_runGate = pwdata & GATE_WRITABLE;
                SLEEP_PORT_CLOCK_GATE_OFS:
                    next_sleepGate = pwdata & GATE_WRITABLE;
                DEEP_PORT_CLOCK_GATE_OFS:
                    next_deepGate = pwdata & GATE_WRITABLE;
                default:
                    next_runGate = runGate;
            endcase
        end

        // a fault in the clearing cycle is kept: set wins over clear
        next_irqStatus = next_irqStatus | faultEvent;

        next_portClockEnable = gateInForce[PORT_N-1:0];
        next_irq = |(next_irqStatus & irqMask);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            runGate         <= GATE_RESET;
            sleepGate       <= GATE_RESET;
            deepGate        <= GATE_RESET;
            resetCtrl       <= SRCR_RESET;
            clockConfig     <= CFG_RESET;
            irqStatus       <= IRQ_RESET;
            irqMask         <= IRQ_RESET;
            prdata          <= 32'h0000_0000;
            portClockEnable <= '0;
            irq             <= 1'b0;
        end
        else
        begin
            runGate         <= next_runGate;
            sleepGate       <= next_sleepGate;
            deepGate        <= next_deepGate;
            resetCtrl       <= next_resetCtrl;
            clockConfig     <= next_clockConfig;
            irqStatus       <= next_irqStatus;
            irqMask         <= next_irqMask;
            prdata          <= next_prdata;
            portClockEnable <= next_portClockEnable;
            irq             <= next_irq;
        end
    end

    // ----------------------------------------------------------------
    // unit reset holds
    // ----------------------------------------------------------------
    // held straight from the control flops, so release follows the write
    // level, not pulse: a unit stays in reset until software clears its bit
    always_comb
    begin
        converterResetHold   = resetCtrl[CONVERTER_RESET_BIT];
        hibernationResetHold = resetCtrl[HIBERNATION_RESET_BIT];
        watchdogResetHold    = resetCtrl[WATCHDOG_RESET_BIT];
    end

endmodule

`default_nettype wire

// file: verification/cgsr_chk.sv
// Purpose: port checks for the clock gate and soft reset block
// Assumes: zero wait state apb slave
// Notes:   shadows of gate, auto and mask bits follow apb writes
`timescale 1ns/1ps
`default_nettype none
module cgsr_chk
    import cgsr_pkg::*;
(
    input wire logic                          mclk,
    input wire logic                          reset,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [cgsr_pkg::ADDR_W-1:0]   paddr,
    input wire logic [cgsr_pkg::DATA_W-1:0]   pwdata,
    input wire logic [cgsr_pkg::DATA_W-1:0]   prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire cgsr_pkg::cgsr_pwr_mode_e      powerMode,
    input wire logic [cgsr_pkg::DATA_W-1:0]   capabilityMask1,
    input wire logic [cgsr_pkg::PORT_N-1:0]   portAccess,
    input wire logic [cgsr_pkg::PORT_N-1:0]   portBusFault,
    input wire logic [cgsr_pkg::PORT_N-1:0]   portClockEnable,
    input wire logic                          converterResetHold,
    input wire logic                          hibernationResetHold,
    input wire logic                          watchdogResetHold,
    input wire logic                          irq
);
    logic [7:0] runG, slpG, dpG, irqMask, gateNow;
    logic       auto;
    wire        wrEn  = psel && penable && pwrite;
    wire  [2:0] hold  = {converterResetHold, hibernationResetHold, watchdogResetHold};
    wire  [2:0] wBits = {pwdata[16], pwdata[6], pwdata[3]};
    wire  [2:0] cBits = {capabilityMask1[16], capabilityMask1[6], capabilityMask1[3]};
    always_ff @(posedge mclk or posedge reset)
        if (reset)
            {auto, runG, slpG, dpG, irqMask} <= '0;
        else if (wrEn)
            case (paddr)
                RUN_MODE_CLOCK_CONFIG_OFS: auto    <= pwdata[0];
                RUN_PORT_CLOCK_GATE_OFS:   runG    <= pwdata[7:0];
                SLEEP_PORT_CLOCK_GATE_OFS: slpG    <= pwdata[7:0];
                DEEP_PORT_CLOCK_GATE_OFS:  dpG     <= pwdata[7:0];
                IRQ_MASK_OFS:              irqMask <= pwdata[7:0];
                default: ;
            endcase
    // mode 2 falls back to the run gate
    always_comb
        gateNow = !auto ? runG : powerMode == PWR_SLEEP ? slpG
                : powerMode == PWR_DEEP ? dpG : runG;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence srcrWr;
        wrEn && paddr == SOFTWARE_RESET_CTRL_0_OFS;
    endsequence
    sequence rdAcc;
        psel && penable && !pwrite;
    endsequence
    a_fault_comb: assert property (
        portBusFault == (portAccess & ~$past(gateNow))) else $error("bad fault");
    a_ready_high: assert property (
        psel && penable |-> pready) else $error("pready low in access");
    a_reset_clear: assert property (disable iff (1'b0)
        reset |-> portClockEnable == 8'h00 && !irq) else $error("not cleared");
    a_hold_write: assert property (srcrWr |=>
        hold == (($past(cBits) & $past(wBits)) | (~$past(cBits) & $past(hold))))
        else $error("bad hold write");
    a_hold_keep: assert property (
        !(wrEn && paddr == SOFTWARE_RESET_CTRL_0_OFS) |=> $stable(hold))
        else $error("hold moved");
    a_srcr_read: assert property (rdAcc ##0 paddr == SOFTWARE_RESET_CTRL_0_OFS
        |-> prdata == {15'h0, hold[2], 9'h0, hold[1], 2'h0, hold[0], 3'h0})
        else $error("bad reset ctrl read");
    a_gate_read: assert property (rdAcc ##0 paddr == DEEP_PORT_CLOCK_GATE_OFS
        |-> prdata == {24'h00_0000, dpG}) else $error("bad gate read");
    a_gate_force: assert property (
        portClockEnable == $past(gateNow)) else $error("wrong gate in force");
    a_irq_raise: assert property (
        (portBusFault & irqMask) != 8'h00 |-> ##1 irq) else $error("irq missing");
    a_irq_mask: assert property (
        (irqMask == 8'h00) [*2] |-> !irq) else $error("irq unmasked");
endmodule
bind cgsr_clock_gate_soft_reset cgsr_chk chk (.mclk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .powerMode, .capabilityMask1,
    .portAccess, .portBusFault, .portClockEnable, .converterResetHold,
    .hibernationResetHold, .watchdogResetHold, .irq);
`default_nettype wire

// file: verification/cgsr_apb_master.sv
// Purpose: processor side apb master model
// Assumes: one transfer at a time
// Notes:   waits on pready, no fixed latency assumed
`timescale 1ns/1ps
`default_nettype none
module cgsr_apb_master
    import cgsr_pkg::*;
(
    input  wire logic                        mclk,
    output var  logic                        psel,
    output var  logic                        penable,
    output var  logic                        pwrite,
    output var  logic [cgsr_pkg::ADDR_W-1:0] paddr,
    output var  logic [cgsr_pkg::DATA_W-1:0] pwdata,
    input  wire logic [cgsr_pkg::DATA_W-1:0] prdata,
    input  wire logic                        pready,
    input  wire logic                        pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic e);
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verification/clock_gate_soft_reset_tb_top.sv
// Purpose: register level tests of the clock gate and soft reset block
// Assumes: 200 MHz mclk
// Notes:   expected values come from the tables below
`timescale 1ns/1ps
`default_nettype none
module clock_gate_soft_reset_tb_top;
    import cgsr_pkg::*;
    logic              mclk = 1'b0;
    logic              reset = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, capabilityMask1;
    logic [7:0]        portAccess, portBusFault, portClockEnable;
    logic              converterResetHold, hibernationResetHold, watchdogResetHold;
    cgsr_pwr_mode_e    powerMode;
    cgsr_pwr_mode_e    modes [3] = '{PWR_RUN, PWR_SLEEP, PWR_DEEP};
    logic [7:0]        gexp  [3] = '{8'h0F, 8'h3C, 8'hA5};
    int                n_errors = 0;
    int                checks_done = 0;
    always #2.5 mclk = ~mclk;
    cgsr_apb_master m (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);
    cgsr_clock_gate_soft_reset dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .powerMode, .capabilityMask1, .portAccess,
        .portBusFault, .portClockEnable, .converterResetHold, .hibernationResetHold,
        .watchdogResetHold, .irq);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        m.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        m.xfer(1'b0, a, 32'h0000_0000, q, e);
        check(q, x);
        check({31'h0, e}, {31'h0, xe});
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, tests need about 100 cycles
    initial
    begin
        #50000;
        n_errors++;
        print_verdict();
    end
    initial
    begin
        // raised by nba so the async reset branch sees a real edge at time 0
        reset <= 1'b1;
        powerMode <= PWR_RUN;
        capabilityMask1 <= 32'hFFFF_FFFF;
        portAccess <= 8'h00;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        rd(SOFTWARE_RESET_CTRL_0_OFS, 32'h0000_0000, 1'b0);
        rd(DEEP_PORT_CLOCK_GATE_OFS, 32'h0000_0000, 1'b0);
        check({24'h0, portClockEnable}, 32'h0000_0000);
        wr(DEEP_PORT_CLOCK_GATE_OFS, 32'hFFFF_FFFF);
        rd(DEEP_PORT_CLOCK_GATE_OFS, 32'h0000_00FF, 1'b0);
        wr(SOFTWARE_RESET_CTRL_0_OFS, 32'hFFFF_FFFF);
        rd(SOFTWARE_RESET_CTRL_0_OFS, 32'h0001_0048, 1'b0);
        check({29'h0, converterResetHold, hibernationResetHold, watchdogResetHold},
            32'h0000_0007);
        capabilityMask1 <= 32'h0000_0008;
        wr(SOFTWARE_RESET_CTRL_0_OFS, 32'h0000_0000);
        rd(SOFTWARE_RESET_CTRL_0_OFS, 32'h0001_0040, 1'b0);
        capabilityMask1 <= 32'hFFFF_FFFF;
        wr(SOFTWARE_RESET_CTRL_0_OFS, 32'h0000_0000);
        // the write lands at the edge the task returns on; look once it has settled
        @(posedge mclk);
        check({29'h0, converterResetHold, hibernationResetHold, watchdogResetHold},
            32'h0000_0000);
        wr(RUN_PORT_CLOCK_GATE_OFS, 32'h0000_000F);
        wr(SLEEP_PORT_CLOCK_GATE_OFS, 32'h0000_003C);
        wr(DEEP_PORT_CLOCK_GATE_OFS, 32'h0000_00A5);
        for (int a = 0; a < 2; a++)
        begin
            wr(RUN_MODE_CLOCK_CONFIG_OFS, 32'(a));
            for (int k = 0; k < 3; k++)
            begin
                powerMode <= modes[k];
                repeat (3) @(posedge mclk);
                check({24'h0, portClockEnable}, {24'h0, a ? gexp[k] : gexp[0]});
            end
        end
        wr(IRQ_MASK_OFS, 32'h0000_0002);
        portAccess <= 8'hFF;
        repeat (2) @(posedge mclk);
        check({24'h0, portBusFault}, 32'h0000_005A);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h0000_0001);
        portAccess <= 8'h00;
        rd(IRQ_STATUS_OFS, 32'h0000_005A, 1'b0);
        wr(IRQ_MASK_OFS, 32'h0000_0000);
        repeat (3) @(posedge mclk);
        check({31'h0, irq}, 32'h0000_0000);
        wr(IRQ_STATUS_OFS, 32'h0000_00FF);
        rd(IRQ_STATUS_OFS, 32'h0000_0000, 1'b0);
        wr(12'h0FC, 32'hFFFF_FFFF);
        rd(12'h0FC, 32'h0000_0000, 1'b1);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(DEEP_PORT_CLOCK_GATE_OFS, 32'h0000_0000, 1'b0);
        check({24'h0, portClockEnable}, 32'h0000_0000);
        print_verdict();
    end
endmodule
`default_nettype wire
